// [inc/fsp_pkg.sv]
// Purpose: Shared constants and types for the flash sector protect and lock block
// Assumes: SPI mode 0 or 3, MSB first, one status byte per write
// Notes:   Sector map and opcode values kept here so every file agrees
package fsp_pkg;

  // Serial opcodes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_READ_PROT    = 8'h3c;

  // Sector map: equal sectors chosen by address bits 18..16
  localparam int unsigned NUM_SECTORS     = 8;
  localparam int unsigned SECT_IDX_W      = 3;
  localparam int unsigned SECT_ADDR_LSB   = 16;
  localparam int unsigned ADDR_W          = 24;
  localparam logic [1:0]  ADDR_LAST_BYTE  = 2'h2;
  localparam logic [2:0]  BIT_LAST        = 3'h7;

  // Status byte fields
  localparam int unsigned ST_LOCK_BIT     = 7;
  localparam int unsigned ST_WPP_BIT      = 4;
  localparam int unsigned ST_SWP_HI       = 3;
  localparam int unsigned ST_SWP_LO       = 2;
  localparam int unsigned ST_GLOB_HI      = 5;
  localparam int unsigned ST_GLOB_LO      = 2;
  localparam logic [3:0]  GLOB_UNPROTECT  = 4'h0;
  localparam logic [3:0]  GLOB_PROTECT    = 4'hf;

  // Protection read reply bytes
  localparam logic [7:0]  PROT_BYTE_SET   = 8'hff;
  localparam logic [7:0]  PROT_BYTE_CLR   = 8'h00;

  // Software protection summary codes
  localparam logic [1:0]  SWP_NONE        = 2'h0;
  localparam logic [1:0]  SWP_SOME        = 2'h1;
  localparam logic [1:0]  SWP_ALL         = 2'h3;

  // Reset values
  localparam logic        LOCK_RST        = 1'b0;

  typedef logic [NUM_SECTORS-1:0] fsp_sect_vec_t;

  localparam fsp_sect_vec_t PROT_RST      = '1;
  localparam fsp_sect_vec_t PROT_NONE     = '0;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CMD,
    PH_ADDR,
    PH_WSTAT,
    PH_RSTAT,
    PH_RPROT,
    PH_IGNORE
  } fsp_phase_t;

endpackage

// [design/fsp_pin_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/10ps
module fsp_pin_sync #(
  parameter int unsigned WIDTH   = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } fsp_sync_st_t;

  fsp_sync_st_t st_r;
  fsp_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{s1: {WIDTH{RST_VAL}}, s2: {WIDTH{RST_VAL}}, s3: {WIDTH{RST_VAL}},
                q: {WIDTH{RST_VAL}}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_q = st_r.q;

endmodule // fsp_pin_sync

// [design/fsp_protect_lock.sv]
// Purpose: Sector protection and lock logic behind the serial flash SPI pins
// Assumes: SPI mode 0 or 3; pins sampled by clk_sys, well above the serial rate
// Notes:   Status write takes effect when its first data byte completes
`timescale 1ns/10ps
module fsp_protect_lock (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   spi_sck,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_si,
  input  wire logic                   wp_n,
  output logic                        spi_so,
  output logic                        spi_so_oe_n,
  output logic                        protect_regs_lock_bit,
  output fsp_pkg::fsp_sect_vec_t      sector_prot,
  output logic [1:0]                  sw_protect_summary,
  output logic                        hw_locked
);
  import fsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] pins_async;
  logic [3:0] pins_q;
  logic       sck_q;
  logic       cs_n_q;
  logic       si_q;
  logic       wp_n_q;

  assign pins_async = {wp_n, spi_si, spi_cs_n, spi_sck};

  fsp_pin_sync #(
    .WIDTH   (4),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .pin_async (pins_async),
    .pin_q     (pins_q)
  );

  assign sck_q  = pins_q[0];
  assign cs_n_q = pins_q[1];
  assign si_q   = pins_q[2];
  assign wp_n_q = pins_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    fsp_phase_t          phase;
    logic                sck_d;
    logic [2:0]          bit_cnt;
    logic [1:0]          addr_cnt;
    logic [7:0]          shift;
    logic [ADDR_W-1:0]   addr;
    logic [7:0]          out_byte;
    logic [2:0]          out_idx;
    logic                so;
    logic                so_oe_n;
    logic                lock;
    fsp_sect_vec_t       prot;
  } fsp_st_t;

  fsp_st_t st_r;
  fsp_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Derived status

  logic                  prot_all;
  logic                  prot_any;
  logic [1:0]            summary;
  logic [7:0]            status_byte;
  logic [SECT_IDX_W-1:0] sect_idx;
  logic [7:0]            prot_byte;

  assign prot_all = &st_r.prot;
  assign prot_any = |st_r.prot;

  always_comb begin
    if (prot_all) begin
      summary = SWP_ALL;
    end else if (prot_any) begin
      summary = SWP_SOME;
    end else begin
      summary = SWP_NONE;
    end
  end

  // Read-back never shows written bits 5..2
  always_comb begin
    status_byte                        = '0;
    status_byte[ST_LOCK_BIT]           = st_r.lock;
    status_byte[ST_WPP_BIT]            = wp_n_q;
    status_byte[ST_SWP_HI:ST_SWP_LO]   = summary;
  end

  assign sect_idx  = st_r.addr[SECT_ADDR_LSB +: SECT_IDX_W];
  // Pin state plays no part here
  assign prot_byte = st_r.prot[sect_idx] ? PROT_BYTE_SET : PROT_BYTE_CLR;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] sh_in;
  logic       byte_done;
  logic [3:0] glob_field;
  logic [7:0] load_byte;
  logic       first_bit;
  fsp_phase_t ph_eff;

  assign sck_rise   = sck_q & ~st_r.sck_d;
  assign sck_fall   = ~sck_q & st_r.sck_d;
  assign sh_in      = {st_r.shift[6:0], si_q};
  assign byte_done  = (st_r.bit_cnt == BIT_LAST);
  assign glob_field = sh_in[ST_GLOB_HI:ST_GLOB_LO];
  assign first_bit  = (st_r.out_idx == '0);
  assign ph_eff     = (st_r.phase == PH_IDLE) ? PH_CMD : st_r.phase;

  // Each reply byte is sampled afresh at its first bit
  always_comb begin
    load_byte = first_bit ?
                ((st_r.phase == PH_RSTAT) ? status_byte : prot_byte) : st_r.out_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters and address capture

  logic [2:0]        bit_cnt_inc;
  logic [1:0]        addr_cnt_inc;
  logic [ADDR_W-1:0] addr_shift;
  logic              addr_last;

  assign bit_cnt_inc  = st_r.bit_cnt + 3'h1;
  assign addr_cnt_inc = st_r.addr_cnt + 2'h1;
  assign addr_shift   = {st_r.addr[ADDR_W-9:0], sh_in};
  assign addr_last    = (st_r.addr_cnt == ADDR_LAST_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode

  fsp_phase_t cmd_phase;

  always_comb begin
    unique case (sh_in)
      OP_WRITE_STATUS: begin
        cmd_phase = PH_WSTAT;
      end
      OP_READ_STATUS: begin
        cmd_phase = PH_RSTAT;
      end
      OP_READ_PROT: begin
        cmd_phase = PH_ADDR;
      end
      default: begin
        cmd_phase = PH_IGNORE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status write decode

  logic          hard_lock;
  logic          soft_lock;
  logic          glob_unprot;
  logic          glob_prot;
  logic          wr_lock_val;
  fsp_sect_vec_t wr_prot_val;

  assign hard_lock   = st_r.lock & ~wp_n_q;
  assign soft_lock   = st_r.lock & wp_n_q;
  assign glob_unprot = (glob_field == GLOB_UNPROTECT);
  assign glob_prot   = (glob_field == GLOB_PROTECT);

  // Bits 5..2 steer the global action and are never kept
  always_comb begin
    wr_lock_val = st_r.lock;
    wr_prot_val = st_r.prot;
    if (hard_lock) begin
      wr_lock_val = st_r.lock;
    end else if (soft_lock) begin
      // Lock may clear, globals wait for a second write
      wr_lock_val = sh_in[ST_LOCK_BIT];
    end else begin
      wr_lock_val = sh_in[ST_LOCK_BIT];
      if (glob_unprot) begin
        wr_prot_val = PROT_NONE;
      end else if (glob_prot) begin
        wr_prot_val = PROT_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply shifter

  logic       out_phase;
  logic       out_step;
  logic       so_bit;
  logic [7:0] so_shift;
  logic [2:0] so_idx;

  assign out_phase = (ph_eff == PH_RSTAT) || (ph_eff == PH_RPROT);
  assign out_step  = sck_fall & out_phase;
  assign so_bit    = load_byte[7];
  assign so_shift  = {load_byte[6:0], 1'b0};
  assign so_idx    = st_r.out_idx + 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_comb begin
    st_nxt       = st_r;
    st_nxt.sck_d = sck_q;

    if (cs_n_q) begin
      // Release at any point ends the command and floats output
      st_nxt.phase    = PH_IDLE;
      st_nxt.bit_cnt  = '0;
      st_nxt.addr_cnt = '0;
      st_nxt.out_idx  = '0;
      st_nxt.so_oe_n  = 1'b1;
    end else begin
      st_nxt.phase = ph_eff;

      if (sck_rise) begin
        st_nxt.shift   = sh_in;
        st_nxt.bit_cnt = bit_cnt_inc;
        if (byte_done) begin
          unique case (ph_eff)
            PH_CMD: begin
              st_nxt.phase = cmd_phase;
            end
            PH_ADDR: begin
              st_nxt.addr     = addr_shift;
              st_nxt.addr_cnt = addr_cnt_inc;
              if (addr_last) begin
                st_nxt.phase = PH_RPROT;
              end
            end
            PH_WSTAT: begin
              // Only the first data byte counts
              st_nxt.phase = PH_IGNORE;
              st_nxt.lock  = wr_lock_val;
              st_nxt.prot  = wr_prot_val;
            end
            PH_IDLE, PH_RSTAT, PH_RPROT, PH_IGNORE: begin
              st_nxt.phase = ph_eff;
            end
          endcase
        end
      end

      // Shift out MSB first on each falling edge, byte reloads on wrap
      if (out_step) begin
        st_nxt.so       = so_bit;
        st_nxt.out_byte = so_shift;
        st_nxt.out_idx  = so_idx;
        st_nxt.so_oe_n  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.phase    <= PH_IDLE;
      st_r.sck_d    <= 1'b1;
      st_r.bit_cnt  <= '0;
      st_r.addr_cnt <= '0;
      st_r.shift    <= '0;
      st_r.addr     <= '0;
      st_r.out_byte <= '0;
      st_r.out_idx  <= '0;
      st_r.so       <= 1'b0;
      st_r.so_oe_n  <= 1'b1;
      st_r.lock     <= LOCK_RST;
      st_r.prot     <= PROT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign spi_so                = st_r.so;
  assign spi_so_oe_n           = st_r.so_oe_n;
  assign protect_regs_lock_bit = st_r.lock;
  assign sector_prot           = st_r.prot;
  assign sw_protect_summary    = summary;
  assign hw_locked             = hard_lock;

endmodule // fsp_protect_lock

// [sim/fsp_host_model.sv]
// Purpose: SPI host model, mode 0, MSB first, 200 ns serial period
// Assumes: Link timing unrelated to clk_sys apart from a fixed offset
// Notes:   Reply bits read as z while the device is not driving
`timescale 1ns/10ps
module fsp_host_model (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si,
  input  wire logic spi_so,
  input  wire logic spi_so_oe_n
);
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // One framed command: ntx bits of tx from the top, then nrx reply bits
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [15:0] rx);
    rx = 16'h0;
    #13 spi_cs_n = 1'b0;
    for (int i = 0; i < ntx; i++) begin
      spi_si = tx[39-i];
      #100 spi_sck = 1'b1;
      #100 spi_sck = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      spi_si = ~spi_si;
      #100 spi_sck = 1'b1;
      #95 rx = {rx[14:0], spi_so_oe_n ? 1'bz : spi_so};
      #5 spi_sck = 1'b0;
    end
    #100 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #300;
  endtask
endmodule // fsp_host_model

// [sim/fsp_protect_lock_properties.sv]
// Purpose: Port-level properties of the protect and lock block
// Assumes: wp_n held steady across frames
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
module fsp_protect_lock_properties
  import fsp_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          srst,
  input wire logic          spi_cs_n,
  input wire logic          wp_n,
  input wire logic          spi_so_oe_n,
  input wire logic          protect_regs_lock_bit,
  input wire fsp_sect_vec_t sector_prot,
  input wire logic [1:0]    sw_protect_summary,
  input wire logic          hw_locked
);
  default clocking cb @(posedge clk_sys); endclocking

  sequence cs_idle;
    spi_cs_n [*6];
  endsequence

  a_reset_vals: assert property (srst |=> sector_prot == PROT_RST
    && protect_regs_lock_bit == LOCK_RST && spi_so_oe_n) else $error("reset values wrong");
  a_summary_code: assert property (disable iff (srst) sw_protect_summary ==
    (&sector_prot ? SWP_ALL : (|sector_prot ? SWP_SOME : SWP_NONE)))
    else $error("summary wrong");
  a_hw_needs_lock: assert property (disable iff (srst) hw_locked |->
    protect_regs_lock_bit && !$past(wp_n, 4)) else $error("hard lock without cause");
  a_hard_lock_hold: assert property (disable iff (srst) hw_locked |=>
    protect_regs_lock_bit) else $error("hard lock lost");
  a_soft_lock_hold: assert property (disable iff (srst) protect_regs_lock_bit |=>
    $stable(sector_prot)) else $error("sectors changed under lock");
  a_lock_fall_wp: assert property (disable iff (srst) $fell(protect_regs_lock_bit) |->
    wp_n) else $error("lock cleared with pin asserted");
  a_oe_release: assert property (disable iff (srst) cs_idle |-> spi_so_oe_n)
    else $error("output driven without select");
  a_idle_stable: assert property (disable iff (srst) spi_cs_n [*8] |=>
    $stable(sector_prot) && $stable(protect_regs_lock_bit)) else $error("change out of frame");
endmodule // fsp_protect_lock_properties

bind fsp_protect_lock fsp_protect_lock_properties u_props (.clk_sys, .srst, .spi_cs_n,
  .wp_n, .spi_so_oe_n, .protect_regs_lock_bit, .sector_prot, .sw_protect_summary,
  .hw_locked);

// [sim/fsp_protect_lock_test.sv]
// Purpose: Self-checking bench for the protect and lock block
// Assumes: 40 MHz clk_sys, host model on the SPI pins
// Notes:   Frames end with a gap long enough for syncs to settle
`timescale 1ns/10ps
module fsp_protect_lock_test;
  import fsp_pkg::*;
  logic          clk_sys = 1'b0;
  logic          srst    = 1'b1;
  logic          wp_n    = 1'b1;
  logic          spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n, lock, hw_locked;
  fsp_sect_vec_t sector_prot;
  logic [1:0]    sw_protect_summary;
  logic [15:0]   rx;
  int            error_cnt = 0;
  int            tests_run = 0;

  always #12.5 clk_sys = ~clk_sys;

  fsp_protect_lock DUT (.clk_sys, .srst, .spi_sck, .spi_cs_n, .spi_si, .wp_n, .spi_so,
    .spi_so_oe_n, .protect_regs_lock_bit(lock), .sector_prot, .sw_protect_summary,
    .hw_locked);
  fsp_host_model host (.spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic st(input logic l, input fsp_sect_vec_t p);
    check({7'h0, lock, sector_prot}, {7'h0, l, p});
    check({15'h0, spi_so_oe_n}, 16'h1);
  endtask

  task automatic wr(input logic [7:0] d);
    host.frame({OP_WRITE_STATUS, d, 24'h0}, 16, 0, rx);
  endtask

  task automatic rd_prot(input logic [2:0] sect, input int n);
    host.frame({OP_READ_PROT, 5'h0, sect, 16'h5a5a, 8'h0}, 32, n, rx);
  endtask

  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    #2 srst = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2;
    st(LOCK_RST, PROT_RST);
    wr(8'h00); st(1'b0, PROT_NONE);
    check({14'h0, sw_protect_summary}, {14'h0, SWP_NONE});
    rd_prot(3'h3, 16); check(rx, {2{PROT_BYTE_CLR}});
    wr(8'h7f); st(1'b0, PROT_RST);
    check({14'h0, sw_protect_summary}, {14'h0, SWP_ALL});
    host.frame({OP_READ_STATUS, 32'h0}, 8, 8, rx);
    check(rx, 16'h001c);
    wr(8'h00); wr(8'hf0); st(1'b1, PROT_NONE);
    wr(8'h0f); st(1'b0, PROT_NONE);
    wr(8'hff); st(1'b1, PROT_RST);
    wr(8'h00); st(1'b0, PROT_RST);
    wr(8'h00); st(1'b0, PROT_NONE);
    wr(8'hff);
    @(posedge clk_sys) #2 wp_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2;
    wr(8'h00); wr(8'h0f); st(1'b1, PROT_RST);
    check({15'h0, hw_locked}, 16'h1);
    host.frame({OP_READ_STATUS, 32'h0}, 8, 16, rx);
    check(rx, 16'h8c8c);
    rd_prot(3'h6, 16); check(rx, {2{PROT_BYTE_SET}});
    rd_prot(3'h1, 3); check(rx, 16'h0007);
    st(1'b1, PROT_RST);
    @(posedge clk_sys) #2 srst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #2 srst = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2;
    st(LOCK_RST, PROT_RST);
    check({15'h0, hw_locked}, 16'h0);
    final_report();
  end
endmodule // fsp_protect_lock_test
